// ===== core/gpt_timer_unit.sv
// Five-timer general purpose timer unit with an AXI4-Lite register slave.
// Assumes asynchronous pins (synchronised here) and a single 250 MHz aclk.
`timescale 1ns/1ps
`default_nettype none
`include "gpt_params.svh"
module gpt_timer_unit
  import gpt_pkg::*;
(
  input wire logic aclk, // 250 MHz clock
  input wire logic aresetn, // Synchronous reset
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [4:0] timer_input_pin, // Gate or count input per timer
  input wire logic [4:0] direction_control_pin, // External direction per timer
  input wire logic capture_trigger_pin, // Capture trigger
  output logic toggle_output_pin, // Core toggle latch
  output logic toggle_output_en, // Core toggle pin enable
  output logic aux_toggle_output_pin, // High aux toggle latch
  output logic aux_toggle_output_en, // High aux toggle pin enable
  output logic second_toggle_output_pin, // Second core toggle latch
  output logic second_toggle_output_en, // Second core toggle pin enable
  output logic compare_tick, // Second core wrap pulse
  output logic [5:0] irq_req, // Flag and enable per source
  output logic [23:0] irq_prio // Priority field per source
);
  localparam int M1_SH = $clog2(`GPT_M1_DIV);
  localparam int M2_SH = $clog2(`GPT_M2_DIV);

  gpt_state_t st;
  gpt_state_t next_st;
  gpt_mode_t md [`GPT_NT];
  logic [`GPT_NT-1:0] en;
  logic [`GPT_NT-1:0] dn;
  logic [`GPT_NT-1:0] wrap;
  logic [`GPT_NT-1:0] pedge;
  logic [`GPT_NT-1:0] rl;
  logic [`GPT_NT-1:0] cp;
  logic core_rise;
  logic core_fall;
  logic core_load;
  logic crev;
  logic wexec;
  logic cap_rise;
  logic cap_fall;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic sel_edge(input logic [1:0] s, input logic r, input logic f);
    return ((s == `GPT_EDGE_RISE) && r) || ((s == `GPT_EDGE_FALL) && f) ||
           ((s == `GPT_EDGE_BOTH) && (r || f));
  endfunction : sel_edge

  // Latch transitions seen one cycle late; edges judged on the second sync stage
  assign core_rise = st.tl_core & ~st.tl_core_q;
  assign core_fall = ~st.tl_core & st.tl_core_q;
  assign cap_rise = st.s2[`GPT_PIN_CAP] & ~st.prev[`GPT_PIN_CAP];
  assign cap_fall = ~st.s2[`GPT_PIN_CAP] & st.prev[`GPT_PIN_CAP];
  assign crev = sel_edge(st.ctrl[3][12:11], cap_rise, cap_fall);
  assign wexec = st.aw_got & st.w_got & ~st.bvalid;
  assign core_load = rl[0] | rl[2];

  for (genvar i = 0; i < `GPT_NT; i++) begin : g_tmr
    localparam int SH = (i < 3) ? M1_SH : M2_SH;
    logic [15:0] c;
    logic [1:0] esel;
    logic tick;
    logic rise;
    logic fall;
    logic lat_ev;
    logic cnt_ev;
    logic gate;
    assign c = st.ctrl[i];
    assign md[i] = gpt_mode_t'(c[5:3]);
    assign esel = c[10:9];
    // Prescaled tick: base divide per module times two to the power of the field
    assign tick = (st.pre & ~({`GPT_PRE_W{1'b1}} << (SH + int'(c[2:0])))) == '0;
    assign rise = st.s2[i] & ~st.prev[i];
    assign fall = ~st.s2[i] & st.prev[i];
    assign pedge[i] = sel_edge(esel, rise, fall);
    // Edge field zero chains the aux timers to the module's toggle latch instead of the pin; the cores then see no event
    assign lat_ev = (i == 0 || i == 2) ? (st.tl_core != st.tl_core_q) :
                    (i == 3) ? (st.tl_sec != st.tl_sec_q) : 1'b0;
    assign cnt_ev = (esel == 2'h0) ? lat_ev : pedge[i];
    assign gate = (md[i] == GPT_GATED_HI) ? st.s2[i] : ~st.s2[i];
    assign dn[i] = c[`GPT_F_DOWN] ^ (c[`GPT_F_EXTDIR] & st.s2[`GPT_PIN_DIR + i]);
    always_comb begin
      case (md[i])
        GPT_TIMER: en[i] = c[`GPT_F_RUN] & tick;
        GPT_GATED_LO, GPT_GATED_HI: en[i] = c[`GPT_F_RUN] & tick & gate;
        GPT_COUNTER: en[i] = c[`GPT_F_RUN] & cnt_ev;
        default: en[i] = 1'b0;
      endcase
    end
    assign wrap[i] = en[i] & (dn[i] ? (st.cnt[i] == `GPT_CNT_MIN) :
                                      (st.cnt[i] == `GPT_CNT_MAX));
    if (i == 0 || i == 2) begin : g_aux
      assign cp[i] = (md[i] == GPT_CAPTURE) & pedge[i];
      assign rl[i] = (md[i] == GPT_RELOAD) & (pedge[i] |
                     sel_edge(c[12:11], core_rise, core_fall));
    end else begin : g_nonaux
      assign cp[i] = 1'b0;
      assign rl[i] = 1'b0;
    end
  end

  always_comb begin
    logic [5:0] ev;
    logic [5:0] clr;
    logic [31:0] rv;
    logic [31:0] mw;
    logic rhit;
    logic whit;
    next_st = st;
    mw = '0;
    ev = '0;
    clr = '0;
    rv = '0;
    rhit = 1'b0;
    whit = 1'b0;
    // Two flops before any logic looks at a pin
    next_st.s1 = {capture_trigger_pin, direction_control_pin, timer_input_pin};
    next_st.s2 = st.s1;
    next_st.prev = st.s2;
    next_st.pre = st.pre + `GPT_PRE_W'(1);
    next_st.tl_core_q = st.tl_core;
    next_st.tl_sec_q = st.tl_sec;
    next_st.cmp_tick = 1'b0;
    for (int i = 0; i < `GPT_NT; i++) begin
      if (en[i]) begin
        next_st.cnt[i] = dn[i] ? st.cnt[i] - `GPT_CNT_ONE : st.cnt[i] + `GPT_CNT_ONE;
        ev[i] = wrap[i];
      end
    end
    if (wrap[1]) begin
      next_st.tl_core = ~st.tl_core;
    end
    if (wrap[2]) begin
      next_st.tl_auxh = ~st.tl_auxh;
    end
    if (wrap[4]) begin
      next_st.tl_sec = ~st.tl_sec;
      next_st.cmp_tick = 1'b1;
      if (st.ctrl[4][`GPT_F_OPT]) begin
        next_st.cnt[4] = st.capture_reload_register;
      end
    end
    // Reload beats counting; on a double trigger the high aux wins
    for (int j = 0; j < 3; j += 2) begin
      if (cp[j]) begin
        next_st.cnt[j] = st.cnt[1];
        ev[j] = 1'b1;
      end
      if (rl[j]) begin
        next_st.cnt[1] = st.cnt[j];
        ev[j] = 1'b1;
      end
    end
    if (crev) begin
      next_st.capture_reload_register = st.cnt[3];
      ev[5] = 1'b1;
      if (st.ctrl[3][`GPT_F_OPT]) begin
        next_st.cnt[3] = `GPT_CNT_MIN;
      end
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    // Software writes win over hardware count updates of the same cycle
    if (wexec) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      if (st.awaddr[4:2] < 3'(`GPT_NT) && st.awaddr[1:0] == 2'h0) begin
        if (st.awaddr[7:5] == `GPT_RG_CTRL) begin
          mw = merge({16'h0000, st.ctrl[st.awaddr[4:2]]}, st.wdata, st.wstrb);
          next_st.ctrl[st.awaddr[4:2]] = mw[15:0];
          whit = 1'b1;
        end
        if (st.awaddr[7:5] == `GPT_RG_CNT) begin
          mw = merge({16'h0000, st.cnt[st.awaddr[4:2]]}, st.wdata, st.wstrb);
          next_st.cnt[st.awaddr[4:2]] = mw[15:0];
          whit = 1'b1;
        end
      end
      case (st.awaddr)
        `GPT_A_CAPTURE_RELOAD_REGISTER: begin
          mw = merge({16'h0000, st.capture_reload_register}, st.wdata, st.wstrb);
          next_st.capture_reload_register = mw[15:0];
          whit = 1'b1;
        end
        `GPT_A_FLAG: begin
          clr = st.wstrb[0] ? st.wdata[5:0] : 6'h00;
          whit = 1'b1;
        end
        `GPT_A_IEN: begin
          mw = merge({26'h0000000, st.ien}, st.wdata, st.wstrb);
          next_st.ien = mw[5:0];
          whit = 1'b1;
        end
        `GPT_A_PRIO: begin
          mw = merge({8'h00, st.prio}, st.wdata, st.wstrb);
          next_st.prio = mw[23:0];
          whit = 1'b1;
        end
        default: ;
      endcase
      next_st.bresp = whit ? `GPT_RESP_OK : `GPT_RESP_ERR;
    end
    // A source event in the clearing cycle survives the clear
    next_st.flag = (st.flag & ~clr) | ev;
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      if (s_axi_araddr[4:2] < 3'(`GPT_NT) && s_axi_araddr[1:0] == 2'h0) begin
        if (s_axi_araddr[7:5] == `GPT_RG_CTRL) begin
          rv = {16'h0000, st.ctrl[s_axi_araddr[4:2]]};
          rhit = 1'b1;
        end
        if (s_axi_araddr[7:5] == `GPT_RG_CNT) begin
          rv = {16'h0000, st.cnt[s_axi_araddr[4:2]]};
          rhit = 1'b1;
        end
      end
      case (s_axi_araddr)
        `GPT_A_CAPTURE_RELOAD_REGISTER: begin
          rv = {16'h0000, st.capture_reload_register};
          rhit = 1'b1;
        end
        `GPT_A_FLAG: begin
          rv = {26'h0000000, st.flag};
          rhit = 1'b1;
        end
        `GPT_A_IEN: begin
          rv = {26'h0000000, st.ien};
          rhit = 1'b1;
        end
        `GPT_A_PRIO: begin
          rv = {8'h00, st.prio};
          rhit = 1'b1;
        end
        default: ;
      endcase
      next_st.rvalid = 1'b1;
      next_st.rdata = rv;
      next_st.rresp = rhit ? `GPT_RESP_OK : `GPT_RESP_ERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = ~st.aw_got & ~st.bvalid;
  assign s_axi_wready = ~st.w_got & ~st.bvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = ~st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign toggle_output_pin = st.tl_core;
  assign toggle_output_en = st.ctrl[1][`GPT_F_OUTEN];
  assign aux_toggle_output_pin = st.tl_auxh;
  assign aux_toggle_output_en = st.ctrl[2][`GPT_F_OUTEN];
  assign second_toggle_output_pin = st.tl_sec;
  assign second_toggle_output_en = st.ctrl[4][`GPT_F_OUTEN];
  assign compare_tick = st.cmp_tick;
  assign irq_req = st.flag & st.ien;
  assign irq_prio = st.prio;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_TOGGLE: assert property (wrap[1] |=> st.tl_core != $past(st.tl_core))
    else $error("core toggle latch missed a wrap");
  AST_WRAP_UP: assert property (wrap[1] && !dn[1] && !core_load && !wexec
    |=> st.cnt[1] == `GPT_CNT_MIN)
    else $error("core overflow did not wrap to zero");
  AST_DOWN: assert property (en[1] && dn[1] && !wrap[1] && !core_load && !wexec
    |=> st.cnt[1] == $past(st.cnt[1]) - `GPT_CNT_ONE)
    else $error("core did not count down");
  AST_AUX_STOP: assert property ((md[0] == GPT_RELOAD || md[0] == GPT_CAPTURE)
    && !cp[0] && !wexec |=> $stable(st.cnt[0]))
    else $error("aux low counted while capture or reload");
  AST_CAPTURE: assert property (cp[0] && !wexec |=> st.cnt[0] == $past(st.cnt[1]))
    else $error("capture did not copy core value");
  AST_RELOAD: assert property (rl[0] && !rl[2] && !wexec
    |=> st.cnt[1] == $past(st.cnt[0]))
    else $error("reload did not load core");
  AST_GATE: assert property (md[1] == GPT_GATED_HI && !st.s2[1] && !core_load && !wexec
    |=> $stable(st.cnt[1]))
    else $error("gated core counted with gate closed");
  AST_RES1: assert property (en[1] && md[1] != GPT_COUNTER |=> !en[1] [*7])
    else $error("first module ticks faster than eight cycles");
  AST_RES2: assert property (en[4] && md[4] != GPT_COUNTER |=> !en[4] [*3])
    else $error("second module ticks faster than four cycles");
  AST_SEC_WRAP: assert property (wrap[4] |=> compare_tick && st.tl_sec != $past(st.tl_sec))
    else $error("second core wrap lost its tick or toggle");
  AST_CAPTURE_RELOAD_REGISTER: assert property (crev && !wexec |=> st.capture_reload_register == $past(st.cnt[3]))
    else $error("capture register missed second aux value");
  AST_FLAG: assert property (wrap[4] |=> st.flag[4])
    else $error("second core flag not raised");
endmodule : gpt_timer_unit
`default_nettype wire

// ===== inc/gpt_params.svh
// Constants of the general purpose timer unit: offsets, fields, timing.
// Assumes inclusion by the package and by the core; definitions only.
// What this block does
// - Five 16-bit timers in two chainable modules
// - First-module timers: timer, gated or counter mode
// - Timer mode counts prescaled CPU clock ticks
// - Counter mode counts edges on timer input
// - Gated mode counts ticks while gate level active
// - First module resolution 400 ns at 20 MHz
// - Software direction, optionally flipped by direction pin
// - Core and high aux toggle on wraps
// - Toggle latch drives pin or clocks aux
// - Aux in capture/reload mode stops counting
// - Capture copies core into aux on input
// - Reload loads core from aux on trigger
// - Opposite latch transitions alternate reloads for PWM
// - Second module resolution 200 ns at 20 MHz
// - Second timers use prescaler or external edges
// - Second core toggle latch clocks aux or pin
// - Second core wrap ticks compare, reloads from register
// - Capture pin latches second aux, optional clear
// - Each source raises flag, gated by enable, priority
`ifndef GPT_PARAMS_SVH
`define GPT_PARAMS_SVH
`define GPT_REF_MHZ 20
`define GPT_M1_RES_NS 400
`define GPT_M2_RES_NS 200
`define GPT_M1_DIV (`GPT_M1_RES_NS * `GPT_REF_MHZ / 1000)
`define GPT_M2_DIV (`GPT_M2_RES_NS * `GPT_REF_MHZ / 1000)
`define GPT_NT 5
`define GPT_NPIN 11
`define GPT_PIN_DIR 5
`define GPT_PIN_CAP 10
`define GPT_PRE_W 11
`define GPT_CNT_MAX 16'hFFFF
`define GPT_CNT_MIN 16'h0000
`define GPT_CNT_ONE 16'h0001
`define GPT_RG_CTRL 3'h0
`define GPT_RG_CNT 3'h1
`define GPT_A_CAPTURE_RELOAD_REGISTER 8'h40
`define GPT_A_FLAG 8'h44
`define GPT_A_IEN 8'h48
`define GPT_A_PRIO 8'h4C
`define GPT_F_RUN 6
`define GPT_F_DOWN 7
`define GPT_F_EXTDIR 8
`define GPT_F_OUTEN 13
`define GPT_F_OPT 14
`define GPT_EDGE_RISE 2'h1
`define GPT_EDGE_FALL 2'h2
`define GPT_EDGE_BOTH 2'h3
`define GPT_RESP_OK 2'h0
`define GPT_RESP_ERR 2'h2
`endif

// ===== inc/gpt_pkg.sv
// Types of the general purpose timer unit: modes and the core state.
// Assumes gpt_params.svh is on the include path.
`include "gpt_params.svh"
package gpt_pkg;
  typedef enum logic [2:0] {
    GPT_TIMER = 3'h0,
    GPT_COUNTER = 3'h1,
    GPT_GATED_LO = 3'h2,
    GPT_GATED_HI = 3'h3,
    GPT_RELOAD = 3'h4,
    GPT_CAPTURE = 3'h5
  } gpt_mode_t;

  typedef struct packed {
    logic [`GPT_NPIN-1:0] s1;
    logic [`GPT_NPIN-1:0] s2;
    logic [`GPT_NPIN-1:0] prev;
    logic [`GPT_PRE_W-1:0] pre;
    logic [`GPT_NT-1:0][15:0] cnt;
    logic [`GPT_NT-1:0][15:0] ctrl;
    logic [15:0] capture_reload_register;
    logic [5:0] flag;
    logic [5:0] ien;
    logic [23:0] prio;
    logic tl_core;
    logic tl_auxh;
    logic tl_sec;
    logic tl_core_q;
    logic tl_sec_q;
    logic cmp_tick;
    logic aw_got;
    logic w_got;
    logic bvalid;
    logic rvalid;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } gpt_state_t;
endpackage : gpt_pkg

// ===== tb/gpt_pin_model.sv
// Pin-side model: timer inputs, direction lines and capture trigger.
// Assumes its tasks are called right after a rising aclk edge.
`timescale 1ns/1ps
`default_nettype none
module gpt_pin_model (
  input wire logic aclk, // Bench clock
  output logic [4:0] timer_input_pin, // Gate or count lines
  output logic [4:0] direction_control_pin, // Direction lines
  output logic capture_trigger_pin // Capture line
);
  initial begin
    timer_input_pin = 5'h00;
    direction_control_pin = 5'h00;
    capture_trigger_pin = 1'b0;
  end
  // Four cycles per level, well above the two the synchroniser needs
  task pulse(input int i);
    timer_input_pin[i] <= 1'b1;
    repeat (4) @(posedge aclk);
    timer_input_pin[i] <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : pulse
  task cap_pulse;
    capture_trigger_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    capture_trigger_pin <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : cap_pulse
  task level(input int i, input logic v);
    timer_input_pin[i] <= v;
    @(posedge aclk);
  endtask : level
  task dir(input int i, input logic v);
    direction_control_pin[i] <= v;
    @(posedge aclk);
  endtask : dir
endmodule : gpt_pin_model
`default_nettype wire

// ===== tb/tb_general_purpose_timer_unit.sv
// Bench for the timer unit: AXI4-Lite register tasks and pin stimulus.
// Assumes gpt_timer_unit and gpt_pin_model are compiled beforehand.
`timescale 1ns/1ps
`default_nettype none
module tb_general_purpose_timer_unit;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, cap;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [4:0] tin, dirp;
  logic capp, tout, tout_en, atout, atout_en, stout, stout_en, ctick;
  logic [5:0] irq_req;
  logic [23:0] irq_prio;
  int err_total, n_compared, n;

  gpt_timer_unit gpt_timer_unit_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_input_pin(tin),
    .direction_control_pin(dirp), .capture_trigger_pin(capp), .toggle_output_pin(tout),
    .toggle_output_en(tout_en), .aux_toggle_output_pin(atout), .aux_toggle_output_en(atout_en),
    .second_toggle_output_pin(stout), .second_toggle_output_en(stout_en),
    .compare_tick(ctick), .irq_req(irq_req), .irq_prio(irq_prio));
  gpt_pin_model gpt_pin_model_i (.aclk(aclk), .timer_input_pin(tin),
    .direction_control_pin(dirp), .capture_trigger_pin(capp));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task test_done;
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rng(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask : rng

  // Bready rises only after both halves are taken, so no signal is set twice per step
  task wr(input logic [7:0] ad, input logic [31:0] d);
    logic awd, wd;
    awd = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(awd && wd)) begin
      @(posedge aclk);
      if (!awd && s_axi_awready === 1'b1) begin
        awd = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] ad);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    test_done;
  end

  initial begin
    err_total = 0;
    n_compared = 0;
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    cyc(4);
    aresetn <= 1'b1;
    cyc(1);
    // Register access, width and unmapped places
    rd(8'h04); chk(rv, 32'h0);
    rd(8'h60); chk(rv, 32'h0);
    chk(rr, 2'h2);
    wr(8'h60, 32'h1); chk(br, 2'h2);
    wr(8'h24, 32'h1234FFFF); chk(br, 2'h0);
    rd(8'h24); chk(rv, 32'h0000FFFF);
    $display("Test registers done");
    // Core timer wraps up, toggle latch, flag, interrupt enable
    wr(8'h04, 32'h2040);
    for (n = 0; n < 60 && tout !== 1'b1; n++) cyc(1);
    chk(tout, 1'b1);
    chk(tout_en, 1'b1);
    rd(8'h24); rng(rv, 0, 4);
    wr(8'h04, 32'h0);
    rd(8'h44); chk(rv[1], 1'b1);
    wr(8'h48, 32'h02);
    chk(irq_req, 6'h02);
    wr(8'h4C, 32'h000050);
    chk(irq_prio, 24'h000050);
    wr(8'h44, 32'h02);
    rd(8'h44); chk(rv[1], 1'b0);
    chk(irq_req, 6'h00);
    $display("Test core wrap done");
    // High aux counts down through zero
    wr(8'h28, 32'h0);
    wr(8'h08, 32'h20C0);
    for (n = 0; n < 60 && atout !== 1'b1; n++) cyc(1);
    chk(atout, 1'b1);
    chk(atout_en, 1'b1);
    wr(8'h08, 32'h0);
    rd(8'h28); rng(rv, 32'hFFF0, 32'hFFFF);
    $display("Test down count done");
    // Direction pin turns an up count into a down count
    wr(8'h24, 32'h0100);
    gpt_pin_model_i.dir(1, 1'b1);
    wr(8'h04, 32'h0140);
    cyc(100);
    wr(8'h04, 32'h0);
    gpt_pin_model_i.dir(1, 1'b0);
    rd(8'h24); rng(rv, 32'h00F0, 32'h00FF);
    $display("Test direction pin done");
    // Counter mode on rising edges of the low aux input
    wr(8'h20, 32'h0);
    wr(8'h00, 32'h0248);
    repeat (5) gpt_pin_model_i.pulse(0);
    cyc(6);
    rd(8'h20); chk(rv, 32'h5);
    // Gated mode, high level enables; eight cycles per tick
    wr(8'h20, 32'h0);
    wr(8'h00, 32'h0058);
    cyc(80);
    rd(8'h20); chk(rv, 32'h0);
    gpt_pin_model_i.level(0, 1'b1);
    cyc(79);
    gpt_pin_model_i.level(0, 1'b0);
    cyc(10);
    rd(8'h20); rng(rv, 9, 11);
    $display("Test counter and gate done");
    // Capture of the core timer into the low aux
    wr(8'h00, 32'h0228);
    wr(8'h24, 32'h1000);
    wr(8'h04, 32'h0040);
    cyc(40);
    gpt_pin_model_i.pulse(0);
    cyc(8);
    rd(8'h20); rng(rv, 32'h1001, 32'h1020);
    cap = rv;
    cyc(40);
    rd(8'h20); chk(rv, cap);
    wr(8'h00, 32'h0);
    // Reload of the core from the high aux on latch transitions
    wr(8'h28, 32'h8000);
    wr(8'h08, 32'h1820);
    wr(8'h24, 32'hFFF8);
    cyc(100);
    rd(8'h24); rng(rv, 32'h8000, 32'h8010);
    rd(8'h28); chk(rv, 32'h8000);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h0);
    $display("Test capture and reload done");
    // Second core: reload from capture register, compare ticks, latch
    wr(8'h40, 32'hFFF0);
    wr(8'h30, 32'hFFFC);
    wr(8'h10, 32'h6040);
    for (n = 0; n < 100 && ctick !== 1'b1; n++) cyc(1);
    chk(ctick, 1'b1);
    cyc(1);
    for (n = 1; n < 200 && ctick !== 1'b1; n++) cyc(1);
    chk(n, 64);
    chk(stout_en, 1'b1);
    chk(stout, 1'b0);
    wr(8'h10, 32'h0);
    rd(8'h30); rng(rv, 32'hFFF0, 32'hFFFF);
    $display("Test second core done");
    // Capture pin latches the second aux and clears it
    wr(8'h2C, 32'h0);
    wr(8'h0C, 32'h4A48);
    repeat (3) gpt_pin_model_i.pulse(3);
    gpt_pin_model_i.cap_pulse;
    cyc(4);
    rd(8'h40); chk(rv, 32'h3);
    rd(8'h2C); chk(rv, 32'h0);
    rd(8'h44); chk(rv[5], 1'b1);
    $display("Test capture pin done");
    test_done;
  end
endmodule : tb_general_purpose_timer_unit
`default_nettype wire
